/* ccf_cfg.svh */
// Offsets, field positions, reset values and constants of the condition flag block
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH

`define CCF_ACC_W      56
`define CCF_ADDR_W     4
`define CCF_DATA_W     8
`define CCF_OUT_W      48

`define CCF_OFS_CODE   4'h0
`define CCF_OFS_MODE   4'h1
`define CCF_OFS_STAT   4'h2
`define CCF_OFS_MASK   4'h3

`define CCF_FLAG_W     6
`define CCF_MODE_W     4
`define CCF_EV_W       3

`define CCF_MODE_SC_LSB 0
`define CCF_MODE_SC_MSB 1
`define CCF_MODE_SAT    2
`define CCF_MODE_SIXT   3

`define CCF_EV_OVF     0
`define CCF_EV_EXT     1
`define CCF_EV_LIM     2

`define CCF_FLAGS_RST  6'h00
`define CCF_MODE_RST   4'h0
`define CCF_EV_RST     3'h0

`define CCF_POS48      48'h7FFFFFFFFFFF
`define CCF_NEG48      48'h800000000000
`define CCF_POS24      24'h7FFFFF
`define CCF_NEG24      24'h800000

`endif

/* ccf_dp_model.sv */
// Datapath model issuing one arithmetic or logical result per request
`timescale 1ns/1ps
module ccf_dp_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [55:0] op_a,
  input  wire logic [55:0] op_b,
  input  wire logic        op_sub,
  input  wire logic        op_lg,
  output logic             alu_valid,
  output logic      [55:0] alu_res,
  output logic             alu_is_logic,
  output logic             alu_ovf56,
  output logic             alu_carry_upd,
  output logic             alu_carry
);
  logic [56:0] sum;
  // One extra bit so carry or borrow out of bit 55 falls out
  assign sum = op_sub ? {1'b0, op_a} - {1'b0, op_b} : {1'b0, op_a} + {1'b0, op_b};
  // Quiet outputs at time zero
  initial {alu_valid, alu_res, alu_is_logic, alu_ovf56, alu_carry_upd, alu_carry} = '0;
  // Idle result lines toggle, so a stale value never looks fresh
  always @(posedge ref_clk) begin
    alu_valid <= go;
    alu_is_logic <= go & op_lg;
    alu_carry_upd <= go & ~op_lg;
    alu_carry <= go ? sum[56] : ~alu_carry;
    alu_ovf56 <= go & ~op_lg & (op_a[55] == (op_b[55] ^ op_sub)) & (sum[55] != op_a[55]);
    alu_res <= ~go ? ~alu_res : op_lg ? op_a ^ op_b : sum[55:0];
  end
endmodule

/* ccf_eval.sv */
// Combinational evaluation of the six condition flags from one result
`timescale 1ns/1ps
module ccf_eval (
  ccf_eval_if.eval io
);
  import ccf_pkg::*;

  logic fit48;
  logic fit32;

  // Result fits without the extension part in saturation mode
  always_comb begin
    fit48 = &io.res[55:47] | ~|io.res[55:47];
    fit32 = &io.res[55:31] | ~|io.res[55:31];
  end

  // Flag equations; carry ignores saturation mode on purpose
  always_comb begin
    io.flags.e = ccf_ext_cond(io.res, io.scale);
    io.flags.u = ccf_unnorm(io.res, io.scale);
    io.flags.n = io.is_logic ? io.res[47] : io.res[55];
    io.flags.z = (io.res == 56'h0);
    if (io.sat_mode) begin
      io.flags.v = io.ovf56 | ~(io.sixteen ? fit32 : fit48);
    end else begin
      io.flags.v = io.ovf56;
    end
    io.flags.c = io.carry;
  end
endmodule

/* ccf_eval_if.sv */
// Carrier between the flag register top and the flag evaluator
`timescale 1ns/1ps
interface ccf_eval_if;
  import ccf_pkg::*;
  logic [55:0] res;
  ccf_scale_t  scale;
  logic        is_logic;
  logic        ovf56;
  logic        carry;
  logic        sat_mode;
  logic        sixteen;
  ccf_flags_t  flags;

  modport req  (output res, scale, is_logic, ovf56, carry, sat_mode, sixteen, input flags);
  modport eval (input res, scale, is_logic, ovf56, carry, sat_mode, sixteen, output flags);
endinterface

/* ccf_flags.sv */
// Condition flag register with move-source limiter, mode register and interrupt
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_flags
  import ccf_pkg::*;
#(
  parameter int ACC_W = `CCF_ACC_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic [`CCF_ADDR_W-1:0] reg_addr,
  input  wire logic [`CCF_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`CCF_DATA_W-1:0] reg_rdata,
  input  wire logic                   alu_valid,
  input  wire logic [ACC_W-1:0]       alu_res,
  input  wire logic                   alu_is_logic,
  input  wire logic                   alu_ovf56,
  input  wire logic                   alu_carry_upd,
  input  wire logic                   alu_carry,
  input  wire logic                   mv_req,
  input  wire logic [ACC_W-1:0]       mv_acc,
  input  wire logic                   mv_wide,
  output logic      [`CCF_OUT_W-1:0]  mv_data,
  output logic                        mv_limited,
  output logic                        mv_valid,
  output ccf_pkg::ccf_flags_t         flags,
  output logic                        irq
);
  import ccf_pkg::*;

  // The bit positions of the flag equations are fixed to a 56-bit accumulator
  if (ACC_W != `CCF_ACC_W) begin : g_chk_width
    $error("ccf_flags supports only a 56-bit accumulator");
  end

  ccf_flags_t                 flags_ff;
  ccf_flags_t                 nxt_flags;
  logic [`CCF_MODE_W-1:0]     mode_ff;
  logic [`CCF_EV_W-1:0]       stat_ff;
  logic [`CCF_EV_W-1:0]       nxt_stat;
  logic [`CCF_EV_W-1:0]       mask_ff;
  logic [`CCF_EV_W-1:0]       events;
  logic [`CCF_DATA_W-1:0]     rdata_ff;
  logic [`CCF_DATA_W-1:0]     nxt_rdata;
  logic [`CCF_OUT_W-1:0]      mv_data_ff;
  logic [`CCF_OUT_W-1:0]      nxt_mv_data;
  logic                       mv_limited_ff;
  logic                       mv_valid_ff;
  logic                       mv_ext;
  logic                       irq_ff;
  logic                       wr_code;
  logic                       wr_mode;
  logic                       wr_stat;
  logic                       wr_mask;
  ccf_scale_t                 scale;

  ccf_eval_if ev_if ();

  // Register write decode
  always_comb begin
    wr_code = reg_wr && (reg_addr == `CCF_OFS_CODE);
    wr_mode = reg_wr && (reg_addr == `CCF_OFS_MODE);
    wr_stat = reg_wr && (reg_addr == `CCF_OFS_STAT);
    wr_mask = reg_wr && (reg_addr == `CCF_OFS_MASK);
  end

  // Scaling bits high then low in the mode register
  assign scale = ccf_scale_t'(mode_ff[`CCF_MODE_SC_MSB:`CCF_MODE_SC_LSB]);

  // Feed the evaluator with the result being written this cycle
  assign ev_if.res      = alu_res;
  assign ev_if.scale    = scale;
  assign ev_if.is_logic = alu_is_logic;
  assign ev_if.ovf56    = alu_ovf56;
  assign ev_if.carry    = alu_carry;
  assign ev_if.sat_mode = mode_ff[`CCF_MODE_SAT];
  assign ev_if.sixteen  = mode_ff[`CCF_MODE_SIXT];

  ccf_eval u_eval (
    .io (ev_if.eval)
  );

  // Next flags: hardware update beats a software write in the same cycle
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_code) begin
      nxt_flags = ccf_flags_t'(reg_wdata[`CCF_FLAG_W-1:0]);
    end
    if (alu_valid) begin
      nxt_flags.e = ev_if.flags.e;
      nxt_flags.u = ev_if.flags.u;
      nxt_flags.n = ev_if.flags.n;
      nxt_flags.z = ev_if.flags.z;
      nxt_flags.v = ev_if.flags.v;
    end
    if (alu_carry_upd) begin
      nxt_flags.c = ev_if.flags.c;
    end
  end

  // Flags land one edge after the result appears so the next instruction sees them
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= ccf_flags_t'(`CCF_FLAGS_RST);
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Mode register: scaling, saturation and sixteen-bit selects
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= `CCF_MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= reg_wdata[`CCF_MODE_W-1:0];
    end
  end

  // Move-source limiter; 24-bit form sits in the low bits
  always_comb begin
    mv_ext = ccf_ext_cond(mv_acc, scale);
    if (mv_wide) begin
      nxt_mv_data = mv_acc[47:0];
      if (mv_ext) begin
        nxt_mv_data = mv_acc[55] ? `CCF_NEG48 : `CCF_POS48;
      end
    end else begin
      nxt_mv_data = {24'h000000, mv_acc[47:24]};
      if (mv_ext) begin
        nxt_mv_data = {24'h000000, (mv_acc[55] ? `CCF_NEG24 : `CCF_POS24)};
      end
    end
  end

  // Limited move answer one cycle after the request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mv_data_ff    <= 48'h000000000000;
      mv_limited_ff <= 1'b0;
      mv_valid_ff   <= 1'b0;
    end else begin
      mv_valid_ff   <= mv_req;
      mv_limited_ff <= mv_req && mv_ext;
      if (mv_req) begin
        mv_data_ff <= nxt_mv_data;
      end
    end
  end

  // Events: overflow, extension and limiting
  always_comb begin
    events = '0;
    events[`CCF_EV_OVF] = alu_valid && ev_if.flags.v;
    events[`CCF_EV_EXT] = alu_valid && ev_if.flags.e;
    events[`CCF_EV_LIM] = mv_req && mv_ext;
    // Set beats a same-cycle write-one clear so no event is lost
    nxt_stat = (stat_ff & ~(wr_stat ? reg_wdata[`CCF_EV_W-1:0] : `CCF_EV_RST)) | events;
  end

  // Sticky status, mask and registered interrupt level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_ff <= `CCF_EV_RST;
      mask_ff <= `CCF_EV_RST;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_mask) begin
        mask_ff <= reg_wdata[`CCF_EV_W-1:0];
      end
      irq_ff <= |(nxt_stat & (wr_mask ? reg_wdata[`CCF_EV_W-1:0] : mask_ff));
    end
  end

  // Read mux; unmapped addresses and idle cycles read as zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `CCF_OFS_CODE: nxt_rdata = {2'h0, flags_ff};
        `CCF_OFS_MODE: nxt_rdata = {4'h0, mode_ff};
        `CCF_OFS_STAT: nxt_rdata = {5'h00, stat_ff};
        `CCF_OFS_MASK: nxt_rdata = {5'h00, mask_ff};
        default:       nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign flags      = flags_ff;
  assign mv_data    = mv_data_ff;
  assign mv_limited = mv_limited_ff;
  assign mv_valid   = mv_valid_ff;
  assign irq        = irq_ff;

  // Checks on the flag, limiter, read data, status and interrupt behaviour
  chk_reset_clear: assert property (
    @(posedge ref_clk) $rose(resetn) |-> (flags_ff == ccf_flags_t'(`CCF_FLAGS_RST)))
    else $error("flags not zero after reset");

  chk_zero_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    alu_valid |=> (flags_ff.z == ($past(alu_res) == 56'h0)))
    else $error("zero flag wrong");

  chk_neg_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    alu_valid |=> (flags_ff.n == ($past(alu_is_logic) ? $past(alu_res[47]) : $past(alu_res[55]))))
    else $error("negative flag wrong");

  chk_ext_none: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_NONE)
      |=> (flags_ff.e == !(&$past(alu_res[55:47]) || !(|$past(alu_res[55:47])))))
    else $error("extension flag wrong without scaling");

  chk_ext_down: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_DOWN)
      |=> (flags_ff.e == !(&$past(alu_res[55:48]) || !(|$past(alu_res[55:48])))))
    else $error("extension flag wrong in scale down");

  chk_unnorm_up: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_UP)
      |=> (flags_ff.u == ($past(alu_res[46]) == $past(alu_res[45]))))
    else $error("unnormalized flag wrong in scale up");

  chk_unnorm_down: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_DOWN)
      |=> (flags_ff.u == ($past(alu_res[48]) == $past(alu_res[47]))))
    else $error("unnormalized flag wrong in scale down");

  chk_unnorm_none: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_NONE)
      |=> (flags_ff.u == ($past(alu_res[47]) == $past(alu_res[46]))))
    else $error("unnormalized flag wrong without scaling");

  chk_ovf_plain: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && !mode_ff[`CCF_MODE_SAT]) |=> (flags_ff.v == $past(alu_ovf56)))
    else $error("overflow flag wrong outside saturation");

  chk_ovf_sat48: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && mode_ff[`CCF_MODE_SAT] && !mode_ff[`CCF_MODE_SIXT] && !alu_ovf56)
      |=> (flags_ff.v == !(&$past(alu_res[55:47]) || !(|$past(alu_res[55:47])))))
    else $error("overflow flag wrong in saturation");

  chk_carry_copy: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    alu_carry_upd |=> (flags_ff.c == $past(alu_carry)))
    else $error("carry flag not taken");

  chk_limit_pos48: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (mv_req && mv_wide && mv_ext && !mv_acc[55]) |=> (mv_limited && mv_data == `CCF_POS48))
    else $error("positive 48-bit limit wrong");

  chk_limit_neg24: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (mv_req && !mv_wide && mv_ext && mv_acc[55])
      |=> (mv_limited && mv_data == {24'h000000, `CCF_NEG24}))
    else $error("negative 24-bit limit wrong");

  chk_pass_wide: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (mv_req && mv_wide && !mv_ext)
      |=> (!mv_limited && mv_data == $past(mv_acc[47:0])))
    else $error("unlimited 48-bit move altered");

  chk_ext_up: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && scale == CCF_SC_UP)
      |=> (flags_ff.e == !(&$past(alu_res[55:46]) || !(|$past(alu_res[55:46])))))
    else $error("extension flag wrong in scale up");

  chk_ovf_sat32: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_valid && mode_ff[`CCF_MODE_SAT] && mode_ff[`CCF_MODE_SIXT] && !alu_ovf56)
      |=> (flags_ff.v == !(&$past(alu_res[55:31]) || !(|$past(alu_res[55:31])))))
    else $error("overflow flag wrong in sixteen-bit saturation");

  chk_carry_sat: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (alu_carry_upd && mode_ff[`CCF_MODE_SAT]) |=> (flags_ff.c == $past(alu_carry)))
    else $error("carry flag changed by saturation mode");

  chk_rdata_idle: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside a read");

  chk_stat_sticky: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !wr_stat |=> ((stat_ff & $past(stat_ff)) == $past(stat_ff)))
    else $error("status bit dropped without a clear");

  chk_flags_hold: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (!alu_valid && !alu_carry_upd && !wr_code) |=> $stable(flags_ff))
    else $error("flags changed without cause");

  chk_irq_level: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ##1 (irq == |(stat_ff & mask_ff)))
    else $error("interrupt level wrong");

  cov_sat_ovf: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    alu_valid && mode_ff[`CCF_MODE_SAT] && ev_if.flags.v);

  cov_limit_neg: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    mv_req && mv_ext && mv_acc[55]);

  cov_irq_rise: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(irq));

  cov_sixteen_ovf: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    alu_valid && mode_ff[`CCF_MODE_SIXT] && mode_ff[`CCF_MODE_SAT] && ev_if.flags.v);

  cov_stat_clear: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    wr_stat && |(stat_ff & reg_wdata[`CCF_EV_W-1:0]));
endmodule

/* ccf_pkg.sv */
// Types and shared decode functions of the condition flag block
package ccf_pkg;
  `include "ccf_cfg.svh"

  typedef enum logic [1:0] {
    CCF_SC_NONE = 2'h0,
    CCF_SC_DOWN = 2'h1,
    CCF_SC_UP   = 2'h2,
    CCF_SC_RSVD = 2'h3
  } ccf_scale_t;

  // Packed in the bit order of the condition code register
  typedef struct packed {
    logic e;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } ccf_flags_t;

  // High when the signed integer portion is not all ones or all zeros
  function automatic logic ccf_ext_cond(input logic [55:0] v, input ccf_scale_t m);
    logic r;
    r = 1'b0;
    unique case (m)
      CCF_SC_DOWN: r = ~(&v[55:48] | ~|v[55:48]);
      CCF_SC_UP:   r = ~(&v[55:46] | ~|v[55:46]);
      default:     r = ~(&v[55:47] | ~|v[55:47]);
    endcase
    return r;
  endfunction

  // High when the two top bits of the scaled upper portion agree
  function automatic logic ccf_unnorm(input logic [55:0] v, input ccf_scale_t m);
    logic r;
    r = 1'b0;
    unique case (m)
      CCF_SC_DOWN: r = ~(v[48] ^ v[47]);
      CCF_SC_UP:   r = ~(v[46] ^ v[45]);
      default:     r = ~(v[47] ^ v[46]);
    endcase
    return r;
  endfunction
endpackage

/* tb_top.sv */
// Self-checking bench for the condition flag register block
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module tb_top;
  import ccf_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        go = 1'b0;
  logic        op_sub = 1'b0;
  logic        op_lg = 1'b0;
  logic [55:0] op_a = '0;
  logic [55:0] op_b = '0;
  logic [55:0] mv_acc = '0;
  logic [55:0] alu_res;
  logic        mv_req = 1'b0;
  logic        mv_wide = 1'b0;
  logic        alu_valid, alu_is_logic, alu_ovf56, alu_carry_upd, alu_carry;
  logic        mv_limited, mv_valid, irq;
  logic [47:0] mv_data;
  ccf_flags_t  flags;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          seed = 32'h8FB2E1F5;
  logic [7:0]  rd_q[$];
  logic [5:0]  fl_q[$];
  logic [48:0] mv_q[$];
  logic [5:0]  fl = 6'h00;
  logic [3:0]  md = 4'h0;
  logic [2:0]  st = 3'h0;
  logic [2:0]  mk = 3'h0;
  bit          rd_seen, fl_seen;

  always #4 ref_clk = ~ref_clk;

  ccf_dp_model dp (.ref_clk(ref_clk), .go(go), .op_a(op_a), .op_b(op_b), .op_sub(op_sub),
    .op_lg(op_lg), .alu_valid(alu_valid), .alu_res(alu_res), .alu_is_logic(alu_is_logic),
    .alu_ovf56(alu_ovf56), .alu_carry_upd(alu_carry_upd), .alu_carry(alu_carry));
  ccf_flags uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alu_valid(alu_valid), .alu_res(alu_res), .alu_is_logic(alu_is_logic),
    .alu_ovf56(alu_ovf56), .alu_carry_upd(alu_carry_upd), .alu_carry(alu_carry),
    .mv_req(mv_req), .mv_acc(mv_acc), .mv_wide(mv_wide), .mv_data(mv_data),
    .mv_limited(mv_limited), .mv_valid(mv_valid), .flags(flags), .irq(irq));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Low bit of the signed integer portion for a scaling code; 11 acts as none
  function automatic int lob(input logic [3:0] m);
    return (m[1:0] == 2'h1) ? 48 : (m[1:0] == 2'h2) ? 46 : 47;
  endfunction

  function automatic bit uni(input logic [55:0] r, input int lo);
    for (int i = lo; i < 55; i++) if (r[i] !== r[55]) return 1'b0;
    return 1'b1;
  endfunction

  // Shifted sign-extended value, so uniform and ragged tops both occur
  function automatic logic [55:0] rv();
    int x;
    x = $random(seed);
    return 56'(x) << ($unsigned($random(seed)) % 28);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    case (a)
      4'h0: fl = d[5:0];
      4'h1: md = d[3:0];
      4'h2: st = st & ~d[2:0];
      4'h3: mk = d[2:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic alu(input logic [55:0] a, input logic [55:0] b, input logic s, input logic l);
    logic [56:0] t;
    logic [55:0] r;
    logic        e, v;
    int          n;
    t = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    r = l ? a ^ b : t[55:0];
    n = lob(md);
    e = ~uni(r, n);
    v = ~l & (a[55] == (b[55] ^ s)) & (t[55] != a[55]);
    v = v | (md[2] & ~uni(r, md[3] ? 31 : 47));
    fl = {e, r[n] == r[n-1], l ? r[47] : r[55], r == 56'h0,
          v, l ? fl[0] : t[56]};
    fl_q.push_back(fl);
    st = st | {1'b0, e, v};
    go <= 1'b1;
    op_a <= a;
    op_b <= b;
    op_sub <= s;
    op_lg <= l;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic mv(input logic [55:0] a, input logic w);
    logic        l;
    logic [47:0] d;
    l = ~uni(a, lob(md));
    d = w ? a[47:0] : {24'h000000, a[47:24]};
    if (l) d = w ? (a[55] ? `CCF_NEG48 : `CCF_POS48)
                 : {24'h000000, a[55] ? `CCF_NEG24 : `CCF_POS24};
    st[2] = st[2] | l;
    mv_q.push_back({l, d});
    mv_req <= 1'b1;
    mv_acc <= a;
    mv_wide <= w;
    @(posedge ref_clk);
    mv_req <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Results come off the queues as they appear at the outputs
  always @(posedge ref_clk) begin
    #1;
    if (rd_seen) check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 8'hXX);
    if (fl_seen) check(flags, fl_q.size() ? fl_q.pop_front() : 6'hXX);
    if (mv_valid === 1'b1) check({mv_limited, mv_data}, mv_q.size() ? mv_q.pop_front() : 49'hX);
    rd_seen = reg_rd;
    fl_seen = alu_valid;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    check(flags, 6'h00);
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h3F);
    wr(4'h3, 8'h07);
    alu(56'h0, 56'h0, 1'b0, 1'b0);
    mv(56'h00800000000000, 1'b1);
    mv(56'hFF7FFFFFFFFFFF, 1'b0);
    for (int i = 0; i < 60; i++) begin
      wr(4'h1, 8'($random(seed)) & 8'h0F);
      rd(4'h1, {4'h0, md});
      alu(rv(), rv(), 1'($random(seed)), 1'($random(seed)));
      rd(4'h0, {2'h0, fl});
      mv(rv(), 1'($random(seed)));
    end
    rd(4'h2, {5'h00, st});
    #1;
    check(irq, |(st & mk));
    wr(4'h3, 8'h00);
    #1;
    check(irq, 1'b0);
    wr(4'h3, 8'h07);
    wr(4'h2, 8'h07);
    rd(4'h2, 8'h00);
    #1;
    check(irq, 1'b0);
    check(rd_q.size() + fl_q.size() + mv_q.size(), 0);
    resetn <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(flags, 6'h00);
    stop_test();
  end
endmodule
